// File: rtl/pid_debounce.sv
`timescale 1ns/1ps
// ==========================================================
// Per-input debounce filter
// ==========================================================
module pid_debounce
    import pid_pkg::*;
#(
    parameter int CYCLES = PID_DEBOUNCE_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic raw_in,
    output logic level_out
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] CMAX = CW'(CYCLES);

    logic sync_a_q;
    logic sync_b_q;
    logic [CW-1:0] cnt_q;
    logic level_q;
    logic differs;
    logic settled;

    // Mismatch against the accepted level and end of hold time
    assign differs = sync_b_q != level_q;
    assign settled = cnt_q == CMAX;
    assign level_out = level_q;

    // Two-stage sampler, first stage read only by the second
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sync_a_q <= 1'b0;
            sync_b_q <= 1'b0;
        end else begin
            sync_a_q <= raw_in;
            sync_b_q <= sync_a_q;
        end
    end

    // New level accepted only after it held the whole window
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt_q <= '0;
            level_q <= 1'b0;
        end else if (!differs) begin
            cnt_q <= '0; // R10
        end else if (settled) begin
            cnt_q <= '0;
            level_q <= sync_b_q; // R10
        end else begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

endmodule : pid_debounce

// File: rtl/pid_dispatcher.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Function code 0 makes an input do nothing and is every selector's reset value.
// R2 - Code 1 requests one fault clear when the input becomes active, never again while held.
// R3 - A fault clear leaves set any fault whose cause is still present.
// R4 - Code 2 starts the motion task numbered by that input's extra argument.
// R5 - Launch acts only in position mode (2) with service command source (0).
// R6 - A launched task runs to completion and its input is ignored until then.
// R7 - All launch inputs are ignored while a launched task runs.
// R8 - No launch happens while any motion task is active for any reason.
// R9 - A launch starts on the rising transition of the input.
// R10 - Each programmable input is debounced so bounce cannot retrigger.
// R11 - The enable input stands apart from the programmable function selection.
// R12 - Unknown codes act like code 0; edges compare the filtered level to its last value.
module pid_dispatcher
    import pid_pkg::*;
#(
    parameter int N_IN = 7,
    parameter int N_FAULT = 16,
    parameter int DEB_CYC = PID_DEBOUNCE_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [N_IN-1:0] din_raw,
    input wire logic enable_raw,
    input wire logic [N_IN*PID_FN_W-1:0] input_function_select,
    input wire logic [N_IN*PID_ARG_W-1:0] input_extra_argument,
    input wire logic [PID_MODE_W-1:0] op_mode,
    input wire logic [PID_MODE_W-1:0] cmd_source,
    input wire logic [N_FAULT-1:0] fault_raise,
    input wire logic [N_FAULT-1:0] fault_cause,
    input wire logic task_active,
    input wire logic task_done,
    output logic drive_enable,
    output logic [N_IN-1:0] din_level,
    output logic fault_clear_pulse,
    output logic [N_FAULT-1:0] fault_flags,
    output logic task_start,
    output logic [PID_ARG_W-1:0] task_number,
    output logic launch_busy
);

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [PID_FN_W-1:0] fn_of(
        input logic [N_IN*PID_FN_W-1:0] v, input int i);
        fn_of = v[i*PID_FN_W +: PID_FN_W];
    endfunction : fn_of

    // Extra argument field of input i
    function automatic logic [PID_ARG_W-1:0] arg_of(
        input logic [N_IN*PID_ARG_W-1:0] v, input int i);
        arg_of = v[i*PID_ARG_W +: PID_ARG_W];
    endfunction : arg_of

    // ==========================================================
    // Input filtering
    // ==========================================================
    logic [N_IN-1:0] level;
    logic [N_IN-1:0] level_prev_q;
    logic enable_level;

    // One filter per programmable input and one for enable
    for (genvar g = 0; g < N_IN; g++) begin : g_deb
        pid_debounce #(.CYCLES(DEB_CYC)) u_deb (
            .mclk(mclk),
            .sys_rst(sys_rst),
            .raw_in(din_raw[g]), // R10
            .level_out(level[g])
        );
    end

    // Enable input is filtered but never dispatched
    pid_debounce #(.CYCLES(DEB_CYC)) u_deb_en (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .raw_in(enable_raw),
        .level_out(enable_level) // R11
    );

    // Previous filtered level for edge detection
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            level_prev_q <= '0;
        end else begin
            level_prev_q <= level; // R12
        end
    end

    // ==========================================================
    // Function decode
    // ==========================================================
    // Decode, permission and selection nets
    pid_state_e state_q;
    pid_state_e state_d;
    logic [N_IN-1:0] rise;
    logic [N_IN-1:0] is_clr;
    logic [N_IN-1:0] is_launch;
    logic [N_IN-1:0] launch_req;
    logic any_clr;
    logic mode_pos;
    logic src_service;
    logic mode_ok;
    logic idle;
    logic launch_blocked;
    logic launch_ok;
    logic launch_fire;
    logic [PID_ARG_W-1:0] arg_chain [N_IN+1];
    logic [PID_ARG_W-1:0] sel_arg;

    // New filtered high level on each input
    assign rise = level & ~level_prev_q; // R12

    // Per-input decode; codes other than 1 and 2 do nothing
    for (genvar g = 0; g < N_IN; g++) begin : g_dec // R1
        assign is_clr[g] = fn_of(input_function_select, g)
            == PID_FN_FAULT_CLR; // R2
        assign is_launch[g] = fn_of(input_function_select, g)
            == PID_FN_TASK_START; // R12
    end

    // Several clear rises merge into one request
    assign any_clr = |(rise & is_clr); // R2
    assign launch_req = rise & is_launch; // R9

    // ==========================================================
    // Launch permission
    // ==========================================================
    // Launch needs position mode with service command source
    assign mode_pos = op_mode == PID_OPMODE_POSITION;
    assign src_service = cmd_source == PID_CMDSRC_SERVICE;
    assign mode_ok = mode_pos && src_service; // R5

    // Any running task, launched here or not, blocks a launch
    assign idle = state_q == PID_ST_IDLE;
    assign launch_blocked = task_active || !idle; // R8
    assign launch_ok = mode_ok && !launch_blocked; // R8
    assign launch_fire = launch_ok && (|launch_req); // R7

    // Lowest-numbered requesting input wins the argument
    assign arg_chain[N_IN] = '0;
    for (genvar g = 0; g < N_IN; g++) begin : g_sel
        assign arg_chain[g] = launch_req[g]
            ? arg_of(input_extra_argument, g) : arg_chain[g+1];
    end
    assign sel_arg = arg_chain[0];

    // ==========================================================
    // Launch state machine
    // ==========================================================
    // Busy holds off every launch input until completion
    always_comb begin
        case (state_q)
            PID_ST_IDLE: state_d = launch_fire ? PID_ST_BUSY : PID_ST_IDLE;
            PID_ST_BUSY: state_d = task_done ? PID_ST_IDLE : PID_ST_BUSY; // R6
            default: state_d = PID_ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q <= PID_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Registered launch results
    logic task_start_q;
    logic [PID_ARG_W-1:0] task_number_q;

    // Start strobe and task number registered
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            task_start_q <= 1'b0;
            task_number_q <= '0;
        end else begin
            task_start_q <= launch_fire;
            if (launch_fire) begin
                task_number_q <= sel_arg; // R4
            end
        end
    end

    // ==========================================================
    // Fault flags
    // ==========================================================
    logic fault_clear_q;
    logic [N_FAULT-1:0] fault_flags_q;
    logic [N_FAULT-1:0] fault_kept;
    logic [N_FAULT-1:0] fault_flags_d;

    // Clear drops only causeless faults; a raise in that cycle wins
    assign fault_kept = any_clr ? (fault_flags_q & fault_cause)
        : fault_flags_q; // R3
    assign fault_flags_d = fault_raise | fault_kept; // R3

    // Sticky flags and the one-cycle clear request
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fault_flags_q <= '0;
            fault_clear_q <= 1'b0;
        end else begin
            fault_clear_q <= any_clr; // R2
            fault_flags_q <= fault_flags_d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // Filtered levels straight from the filter flip-flops
    assign drive_enable = enable_level;
    assign din_level = level;

    // Registered results to the pins
    assign fault_clear_pulse = fault_clear_q;
    assign fault_flags = fault_flags_q;
    assign task_start = task_start_q;
    assign task_number = task_number_q;

    // Busy mirrors the state register
    assign launch_busy = state_q == PID_ST_BUSY;

endmodule : pid_dispatcher

// File: rtl/pid_pkg.sv
package pid_pkg;

    // ==========================================================
    // Function codes
    // ==========================================================
    localparam logic [4:0] PID_FN_OFF = 5'h00;
    localparam logic [4:0] PID_FN_FAULT_CLR = 5'h01;
    localparam logic [4:0] PID_FN_TASK_START = 5'h02;
    localparam logic [4:0] PID_FN_RESET = PID_FN_OFF;

    // ==========================================================
    // Mode and command source values
    // ==========================================================
    localparam logic [3:0] PID_OPMODE_POSITION = 4'h2;
    localparam logic [3:0] PID_CMDSRC_SERVICE = 4'h0;

    // ==========================================================
    // Field widths and timing
    // ==========================================================
    localparam int PID_FN_W = 5;
    localparam int PID_ARG_W = 8;
    localparam int PID_MODE_W = 4;
    localparam int PID_CLK_MHZ = 50;
    localparam int PID_DEBOUNCE_US = 1;
    localparam int PID_DEBOUNCE_CYC = PID_DEBOUNCE_US * PID_CLK_MHZ;

    // ==========================================================
    // Launch controller states
    // ==========================================================
    typedef enum logic [1:0] {
        PID_ST_IDLE = 2'b01,
        PID_ST_BUSY = 2'b10
    } pid_state_e;

endpackage : pid_pkg

// File: verif/pid_checker.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker for the input dispatcher
// ==========================================================
module pid_checker
    import pid_pkg::*;
#(
    parameter int N_IN = 7,
    parameter int N_FAULT = 16
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [N_IN-1:0] din_level,
    input wire logic [N_IN*PID_FN_W-1:0] input_function_select,
    input wire logic [N_IN*PID_ARG_W-1:0] input_extra_argument,
    input wire logic [PID_MODE_W-1:0] op_mode,
    input wire logic [PID_MODE_W-1:0] cmd_source,
    input wire logic [N_FAULT-1:0] fault_raise,
    input wire logic [N_FAULT-1:0] fault_cause,
    input wire logic [N_FAULT-1:0] fault_flags,
    input wire logic task_active,
    input wire logic task_done,
    input wire logic fault_clear_pulse,
    input wire logic task_start,
    input wire logic [PID_ARG_W-1:0] task_number,
    input wire logic launch_busy
);
    logic [N_IN-1:0] prev_q;
    logic clr_hit;
    logic go_hit;
    logic go_ok;
    logic [PID_ARG_W-1:0] go_arg;
    // Rising filtered levels, lowest input wins the argument
    always_ff @(posedge mclk) prev_q <= din_level;
    always_comb begin
        clr_hit = 1'b0;
        go_hit = 1'b0;
        go_arg = '0;
        for (int i = N_IN - 1; i >= 0; i--) begin
            if (din_level[i] && !prev_q[i]) begin
                if (input_function_select[i*PID_FN_W+:PID_FN_W]
                        == PID_FN_FAULT_CLR)
                    clr_hit = 1'b1;
                if (input_function_select[i*PID_FN_W+:PID_FN_W]
                        == PID_FN_TASK_START) begin
                    go_hit = 1'b1;
                    go_arg = input_extra_argument[i*PID_ARG_W+:PID_ARG_W];
                end
            end
        end
    end
    assign go_ok = go_hit && op_mode == PID_OPMODE_POSITION &&
        cmd_source == PID_CMDSRC_SERVICE && !task_active && !launch_busy;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // ==========================================================
    // Properties
    // ==========================================================
    property p_clr_fire; clr_hit |=> fault_clear_pulse; endproperty
    property p_clr_cause; fault_clear_pulse |-> $past(clr_hit); endproperty
    property p_clr_once;
        fault_clear_pulse && !clr_hit |=> !fault_clear_pulse;
    endproperty
    property p_fault_keep;
        fault_clear_pulse |-> fault_flags == ($past(fault_raise) |
            $past(fault_flags) & $past(fault_cause));
    endproperty
    property p_go;
        go_ok |=> task_start && task_number == $past(go_arg);
    endproperty
    property p_go_cause; task_start |-> $past(go_ok); endproperty
    property p_busy_hold;
        launch_busy && !task_done |=> launch_busy && !task_start;
    endproperty
    property p_busy_end; launch_busy && task_done |=> !launch_busy; endproperty
    a_clr_fire: assert property (p_clr_fire)
        else $error("clear request missing");
    a_clr_cause: assert property (p_clr_cause)
        else $error("clear request without cause");
    a_clr_once: assert property (p_clr_once)
        else $error("clear request repeated");
    a_fault_keep: assert property (p_fault_keep)
        else $error("fault flags wrong after clear");
    a_go: assert property (p_go)
        else $error("launch missing or wrong number");
    a_go_cause: assert property (p_go_cause)
        else $error("launch without permission");
    a_busy_hold: assert property (p_busy_hold)
        else $error("busy dropped or relaunched");
    a_busy_end: assert property (p_busy_end)
        else $error("busy not ended by completion");
    c_clr: cover property (fault_clear_pulse);
    c_go: cover property (task_start);
    c_end: cover property (launch_busy && task_done);
endmodule : pid_checker

bind pid_dispatcher pid_checker #(.N_IN(N_IN), .N_FAULT(N_FAULT)) chk_u (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .din_level(din_level),
    .input_function_select(input_function_select),
    .input_extra_argument(input_extra_argument),
    .op_mode(op_mode),
    .cmd_source(cmd_source),
    .fault_raise(fault_raise),
    .fault_cause(fault_cause),
    .fault_flags(fault_flags),
    .task_active(task_active),
    .task_done(task_done),
    .fault_clear_pulse(fault_clear_pulse),
    .task_start(task_start),
    .task_number(task_number),
    .launch_busy(launch_busy)
);

// File: verif/pid_dispatcher_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
    $display("Error %0t got %h exp %h", $time, a, b); end end
// ==========================================================
// Bench top
// ==========================================================
module pid_dispatcher_tb_top
    import pid_pkg::*;
;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] want = 8'h00;
    logic [6:0] din_raw;
    logic enable_raw;
    logic [34:0] fsel = 35'h0;
    logic [55:0] xarg = 56'h0;
    logic [3:0] op_mode = 4'h2;
    logic [3:0] cmd_source = 4'h0;
    logic [15:0] fault_raise = 16'h0;
    logic [15:0] fault_cause = 16'h0;
    logic task_active = 1'b0;
    logic task_done = 1'b0;
    logic drive_enable, fault_clear_pulse, task_start, launch_busy;
    logic [6:0] din_level;
    logic [15:0] fault_flags;
    logic [7:0] task_number;
    int n_errors = 0;
    int check_count = 0;
    int n_clr, n_go;
    initial begin
        forever #10 mclk = ~mclk;
    end
    pid_switch_model sw_u (.mclk(mclk), .want(want),
        .pins({enable_raw, din_raw}));
    pid_dispatcher #(.DEB_CYC(2)) dut_u (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din_raw(din_raw),
        .enable_raw(enable_raw),
        .input_function_select(fsel),
        .input_extra_argument(xarg),
        .op_mode(op_mode),
        .cmd_source(cmd_source),
        .fault_raise(fault_raise),
        .fault_cause(fault_cause),
        .task_active(task_active),
        .task_done(task_done),
        .drive_enable(drive_enable),
        .din_level(din_level),
        .fault_clear_pulse(fault_clear_pulse),
        .fault_flags(fault_flags),
        .task_start(task_start),
        .task_number(task_number),
        .launch_busy(launch_busy)
    );
    // Set switches, then count pulses over n cycles
    task watch(input int n, input logic [7:0] w);
        @(posedge mclk);
        want <= w;
        n_clr = 0;
        n_go = 0;
        repeat (n) begin
            @(posedge mclk);
            #1;
            n_clr += fault_clear_pulse;
            n_go += task_start;
        end
    endtask : watch
    task finish_task;
        int k;
        @(posedge mclk);
        task_done <= 1'b1;
        for (k = 0; k < 8 && launch_busy !== 1'b0; k++) begin
            @(posedge mclk);
            #1;
        end
        `CHK(launch_busy, 1'b0)
        @(posedge mclk);
        task_done <= 1'b0;
        if (k == 8) wrap_up;
    endtask : finish_task
    task t_off;
        `CHK(fault_flags, 16'h0000)
        @(posedge mclk);
        fsel[34:30] <= 5'h1f;
        watch(40, 8'h7f);
        `CHK(n_clr + n_go, 0)
        `CHK(din_level, 7'h7f)
        watch(40, 8'h00);
        $display("off test done");
    endtask : t_off
    task t_clear;
        @(posedge mclk);
        fault_raise <= 16'h0003;
        fault_cause <= 16'h0002;
        fsel[4:0] <= PID_FN_FAULT_CLR;
        @(posedge mclk);
        fault_raise <= 16'h0000;
        watch(60, 8'h01);
        `CHK(n_clr, 1)
        `CHK(fault_flags, 16'h0002)
        watch(40, 8'h00);
        `CHK(n_clr, 0)
        $display("clear test done");
    endtask : t_clear
    task t_launch;
        @(posedge mclk);
        fsel[19:10] <= {PID_FN_TASK_START, PID_FN_TASK_START};
        xarg[31:16] <= 16'h112a;
        watch(30, 8'h04);
        `CHK(n_go, 1)
        `CHK(task_number, 8'h2a)
        `CHK(launch_busy, 1'b1)
        watch(30, 8'h0c);
        `CHK(n_go, 0)
        watch(30, 8'h00);
        `CHK(n_go, 0)
        watch(30, 8'h04);
        `CHK(n_go, 0)
        watch(30, 8'h00);
        finish_task;
        watch(30, 8'h08);
        `CHK(n_go, 1)
        `CHK(task_number, 8'h11)
        watch(30, 8'h00);
        finish_task;
        watch(30, 8'h0c);
        `CHK(n_go, 1)
        `CHK(task_number, 8'h2a)
        watch(30, 8'h00);
        finish_task;
        $display("launch test done");
    endtask : t_launch
    task t_refuse;
        for (int c = 0; c < 3; c++) begin
            @(posedge mclk);
            op_mode <= c == 0 ? 4'h1 : 4'h2;
            cmd_source <= c == 1 ? 4'h2 : 4'h0;
            task_active <= c == 2;
            watch(30, 8'h08);
            `CHK(n_go, 0)
            watch(30, 8'h00);
        end
        @(posedge mclk);
        op_mode <= 4'h2;
        cmd_source <= 4'h0;
        task_active <= 1'b0;
        $display("refuse test done");
    endtask : t_refuse
    task t_enable;
        watch(30, 8'h80);
        `CHK(drive_enable, 1'b1)
        `CHK(din_level, 7'h00)
        watch(30, 8'h00);
        `CHK(drive_enable, 1'b0)
        $display("enable test done");
    endtask : t_enable
    task wrap_up;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    // Main sequence
    initial begin
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (10) @(posedge mclk);
        t_off;
        t_clear;
        t_launch;
        t_refuse;
        t_enable;
        wrap_up;
    end
endmodule : pid_dispatcher_tb_top

// File: verif/pid_switch_model.sv
`timescale 1ns/1ps
// ==========================================================
// Bank of bouncing switches
// ==========================================================
module pid_switch_model #(
    parameter int BOUNCE = 5
) (
    input wire logic mclk,
    input wire logic [7:0] want,
    output logic [7:0] pins
);
    logic [7:0] last_q = 8'h00;
    int bnc_q = 0;
    // Contacts chatter one-cycle glitches after each change
    always @(posedge mclk) begin
        last_q <= want;
        if (want != last_q) bnc_q <= BOUNCE;
        else if (bnc_q != 0) bnc_q <= bnc_q - 1;
        pins <= bnc_q[0] ? ~want : want;
    end
endmodule : pid_switch_model
